//--- src/pcc_pkg.sv
// constants and types for the prescaler and clock control block
package pcc_pkg;
    // register indexes; byte address is four times the index
    localparam logic [15:0] OSC_CTRL_IDX = 16'hFF01;
    localparam logic [15:0] PRESCALE_SEL_IDX = 16'hFF10;
    localparam logic [15:0] SOURCE_SEL_IDX = 16'hFF12;
    localparam logic [15:0] CLK_OUT_CTRL_IDX = 16'hFF14;
    localparam logic [15:0] EVENT_GATE_IDX = 16'hFF15;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    // field positions
    localparam int FAST_OSC_EN_BIT = 2;
    localparam int T0_DIV_LSB = 0;
    localparam int T0_CLK_EN_BIT = 3;
    localparam int T0_SRC_BIT = 0;
    localparam int FAST_DIV_LSB = 0;
    localparam int FAST_OUT_EN_BIT = 3;
    localparam int SLOW_DIV_LSB = 4;
    localparam int SLOW_OUT_EN_BIT = 7;
    localparam int T0_GATE_BIT = 0;
    localparam int T1_GATE_BIT = 1;
    localparam int DIV_W = 3;
    localparam int CHAIN_W = 7;
    // oscillator channel numbers
    localparam int SLOW_CH = 0;
    localparam int FAST_CH = 1;
    // reset values
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic BIT_RESET = 1'b0;
    localparam logic [6:0] CHAIN_RESET = 7'h00;

    // software control fields
    typedef struct packed {
        logic fast_osc_enable;
        logic timer0_source_select;
        logic [2:0] timer0_divide_field;
        logic timer0_clock_enable;
        logic slow_out_enable;
        logic [2:0] slow_out_divide;
        logic fast_out_enable;
        logic [2:0] fast_out_divide;
        logic timer0_event_gate;
        logic timer1_event_gate;
    } pcc_ctrl_t;

    localparam pcc_ctrl_t CTRL_RESET = '{BIT_RESET, BIT_RESET, DIV_RESET,
        BIT_RESET, BIT_RESET, DIV_RESET, BIT_RESET, DIV_RESET, BIT_RESET,
        BIT_RESET};
endpackage : pcc_pkg

//--- src/pcc_prescaler.sv
// prescaler, clock gating and avalon register slave
`timescale 1ns/1ps
// Behaviour
// - fast oscillator enable starts it at one, stops it at zero, reads back.
// - after reset the fast oscillator enable bit is zero.
// - timer 0 source select takes slow at one, fast at zero, reads back.
// - after reset timer 0 source select is zero, choosing the fast clock.
// - a readable three-bit timer 0 divide field picks one of eight ratios.
// - the timer 0 divide field resets to zero.
// - output divide codes 0 to 7 divide slow and fast by 1 to 128.
// - with slow out enable at one the divided slow clock drives its pin.
// - with fast out enable at one the divided fast clock drives its pin.
// - timer 0 event gate passes the event input at one, blocks it at zero.
// - timer 0 clock enable passes the divided clock at one, not at zero.
module pcc_prescaler (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [pcc_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [pcc_pkg::DATA_W-1:0] AVS_WRITEDATA,
    output logic [pcc_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SLOW_OSC_CLK,
    input wire logic FAST_OSC_CLK,
    input wire logic TIMER0_EVENT_INPUT,
    input wire logic TIMER1_EVENT_INPUT,
    output logic FAST_OSC_ENABLE,
    output logic TIMER0_CLOCK,
    output logic TIMER0_EVENT_CLOCK,
    output logic TIMER1_EVENT_CLOCK,
    output logic SLOW_CLOCK_OUTPUT,
    output logic FAST_CLOCK_OUTPUT
);
    pcc_pkg::pcc_ctrl_t ctrl_reg;
    logic wait_reg;
    logic [pcc_pkg::DATA_W-1:0] rdata_reg;
    logic [pcc_pkg::DATA_W-1:0] rdata_next;
    logic [15:0] idx;
    logic [1:0] osc_pin;
    logic t0_new_tap;
    logic slow_new_tap;
    logic fast_new_tap;
    logic [pcc_pkg::CHAIN_W:0] taps [2];
    logic [1:0] evt_meta_reg;
    logic [1:0] evt_sync_reg;
    logic t0_src_tap;
    logic t0_on_reg;
    logic [2:0] t0_div_reg;
    logic t0_src_reg;
    logic slow_on_reg;
    logic [2:0] slow_div_reg;
    logic fast_on_reg;
    logic [2:0] fast_div_reg;

    assign idx = AVS_ADDRESS[pcc_pkg::ADDR_W-1:2];
    assign osc_pin = {FAST_OSC_CLK, SLOW_OSC_CLK};

    // per oscillator: synchroniser, edge detect, free-running chain
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chain
            logic meta_reg;
            logic sync_reg;
            logic last_reg;
            logic [pcc_pkg::CHAIN_W-1:0] cnt_reg;
            always_ff @(posedge SYS_CLK) begin
                if (RESET) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                    last_reg <= 1'b0;
                    cnt_reg <= pcc_pkg::CHAIN_RESET;
                end else begin
                    meta_reg <= osc_pin[ch];
                    sync_reg <= meta_reg;
                    last_reg <= sync_reg;
                    if (sync_reg && !last_reg) begin
                        cnt_reg <= cnt_reg + 7'h01;
                    end
                end
            end
            // tap 0 is the oscillator, tap n is divide by 2 to the n
            assign taps[ch] = {cnt_reg, sync_reg};
        end
    endgenerate

    // avalon handshake: one wait cycle, then answer
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((AVS_READ || AVS_WRITE) && wait_reg);
        end
    end

    // read mux, unmapped reads give zero
    always_comb begin
        rdata_next = '0;
        case (idx)
            pcc_pkg::OSC_CTRL_IDX: begin
                rdata_next[pcc_pkg::FAST_OSC_EN_BIT] =
                    ctrl_reg.fast_osc_enable;
            end
            pcc_pkg::PRESCALE_SEL_IDX: begin
                rdata_next[pcc_pkg::T0_DIV_LSB +: pcc_pkg::DIV_W] =
                    ctrl_reg.timer0_divide_field;
                rdata_next[pcc_pkg::T0_CLK_EN_BIT] =
                    ctrl_reg.timer0_clock_enable;
            end
            pcc_pkg::SOURCE_SEL_IDX: begin
                rdata_next[pcc_pkg::T0_SRC_BIT] =
                    ctrl_reg.timer0_source_select;
            end
            pcc_pkg::CLK_OUT_CTRL_IDX: begin
                rdata_next[pcc_pkg::FAST_DIV_LSB +: pcc_pkg::DIV_W] =
                    ctrl_reg.fast_out_divide;
                rdata_next[pcc_pkg::FAST_OUT_EN_BIT] =
                    ctrl_reg.fast_out_enable;
                rdata_next[pcc_pkg::SLOW_DIV_LSB +: pcc_pkg::DIV_W] =
                    ctrl_reg.slow_out_divide;
                rdata_next[pcc_pkg::SLOW_OUT_EN_BIT] =
                    ctrl_reg.slow_out_enable;
            end
            pcc_pkg::EVENT_GATE_IDX: begin
                rdata_next[pcc_pkg::T0_GATE_BIT] = ctrl_reg.timer0_event_gate;
                rdata_next[pcc_pkg::T1_GATE_BIT] = ctrl_reg.timer1_event_gate;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // read data captured during the wait cycle
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            rdata_reg <= '0;
        end else if (AVS_READ && wait_reg) begin
            rdata_reg <= rdata_next;
        end
    end

    // register writes at the answering edge
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            ctrl_reg <= pcc_pkg::CTRL_RESET;
        end else if (AVS_WRITE && !wait_reg) begin
            case (idx)
                pcc_pkg::OSC_CTRL_IDX: begin
                    ctrl_reg.fast_osc_enable <=
                        AVS_WRITEDATA[pcc_pkg::FAST_OSC_EN_BIT];
                end
                pcc_pkg::PRESCALE_SEL_IDX: begin
                    ctrl_reg.timer0_divide_field <=
                        AVS_WRITEDATA[pcc_pkg::T0_DIV_LSB +: pcc_pkg::DIV_W];
                    ctrl_reg.timer0_clock_enable <=
                        AVS_WRITEDATA[pcc_pkg::T0_CLK_EN_BIT];
                end
                pcc_pkg::SOURCE_SEL_IDX: begin
                    ctrl_reg.timer0_source_select <=
                        AVS_WRITEDATA[pcc_pkg::T0_SRC_BIT];
                end
                pcc_pkg::CLK_OUT_CTRL_IDX: begin
                    ctrl_reg.fast_out_divide <=
                        AVS_WRITEDATA[pcc_pkg::FAST_DIV_LSB +: pcc_pkg::DIV_W];
                    ctrl_reg.fast_out_enable <=
                        AVS_WRITEDATA[pcc_pkg::FAST_OUT_EN_BIT];
                    ctrl_reg.slow_out_divide <=
                        AVS_WRITEDATA[pcc_pkg::SLOW_DIV_LSB +: pcc_pkg::DIV_W];
                    ctrl_reg.slow_out_enable <=
                        AVS_WRITEDATA[pcc_pkg::SLOW_OUT_EN_BIT];
                end
                pcc_pkg::EVENT_GATE_IDX: begin
                    ctrl_reg.timer0_event_gate <=
                        AVS_WRITEDATA[pcc_pkg::T0_GATE_BIT];
                    ctrl_reg.timer1_event_gate <=
                        AVS_WRITEDATA[pcc_pkg::T1_GATE_BIT];
                end
                default: begin
                    ctrl_reg <= ctrl_reg;
                end
            endcase
        end
    end

    assign t0_src_tap = t0_src_reg ? taps[pcc_pkg::SLOW_CH][t0_div_reg]
                                   : taps[pcc_pkg::FAST_CH][t0_div_reg];

    // taps the pending settings would pick
    assign t0_new_tap = ctrl_reg.timer0_source_select
        ? taps[pcc_pkg::SLOW_CH][ctrl_reg.timer0_divide_field]
        : taps[pcc_pkg::FAST_CH][ctrl_reg.timer0_divide_field];
    assign slow_new_tap = taps[pcc_pkg::SLOW_CH][ctrl_reg.slow_out_divide];
    assign fast_new_tap = taps[pcc_pkg::FAST_CH][ctrl_reg.fast_out_divide];

    // settings move only while output, old tap and new tap are low
    // so no pulse is cut short; a tap frozen high on a stopped oscillator
    // holds the old setting until that oscillator runs again
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            t0_on_reg <= 1'b0;
            t0_div_reg <= pcc_pkg::DIV_RESET;
            t0_src_reg <= 1'b0;
            slow_on_reg <= 1'b0;
            slow_div_reg <= pcc_pkg::DIV_RESET;
            fast_on_reg <= 1'b0;
            fast_div_reg <= pcc_pkg::DIV_RESET;
        end else begin
            if (!TIMER0_CLOCK && !t0_src_tap && !t0_new_tap) begin
                t0_on_reg <= ctrl_reg.timer0_clock_enable;
                t0_div_reg <= ctrl_reg.timer0_divide_field;
                t0_src_reg <= ctrl_reg.timer0_source_select;
            end
            if (!SLOW_CLOCK_OUTPUT && !slow_new_tap &&
                    !taps[pcc_pkg::SLOW_CH][slow_div_reg]) begin
                slow_on_reg <= ctrl_reg.slow_out_enable;
                slow_div_reg <= ctrl_reg.slow_out_divide;
            end
            if (!FAST_CLOCK_OUTPUT && !fast_new_tap &&
                    !taps[pcc_pkg::FAST_CH][fast_div_reg]) begin
                fast_on_reg <= ctrl_reg.fast_out_enable;
                fast_div_reg <= ctrl_reg.fast_out_divide;
            end
        end
    end

    // event inputs: two-flop synchronisers
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            evt_meta_reg <= 2'h0;
            evt_sync_reg <= 2'h0;
        end else begin
            evt_meta_reg <= {TIMER1_EVENT_INPUT, TIMER0_EVENT_INPUT};
            evt_sync_reg <= evt_meta_reg;
        end
    end

    // registered clock outputs
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            TIMER0_CLOCK <= 1'b0;
            SLOW_CLOCK_OUTPUT <= 1'b0;
            FAST_CLOCK_OUTPUT <= 1'b0;
            TIMER0_EVENT_CLOCK <= 1'b0;
            TIMER1_EVENT_CLOCK <= 1'b0;
        end else begin
            TIMER0_CLOCK <= t0_on_reg && t0_src_tap;
            SLOW_CLOCK_OUTPUT <= slow_on_reg &&
                taps[pcc_pkg::SLOW_CH][slow_div_reg];
            FAST_CLOCK_OUTPUT <= fast_on_reg &&
                taps[pcc_pkg::FAST_CH][fast_div_reg];
            TIMER0_EVENT_CLOCK <= ctrl_reg.timer0_event_gate &&
                evt_sync_reg[pcc_pkg::T0_GATE_BIT];
            TIMER1_EVENT_CLOCK <= ctrl_reg.timer1_event_gate &&
                evt_sync_reg[pcc_pkg::T1_GATE_BIT];
        end
    end

    // oscillator enable and bus outputs
    assign FAST_OSC_ENABLE = ctrl_reg.fast_osc_enable;
    assign AVS_WAITREQUEST = wait_reg;
    assign AVS_READDATA = rdata_reg;
endmodule : pcc_prescaler

//--- bench/pcc_chk.sv
// port assertions for the prescaler block
`timescale 1ns/1ps
module pcc_chk (
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [pcc_pkg::DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic TIMER0_EVENT_INPUT,
    input wire logic FAST_OSC_ENABLE,
    input wire logic TIMER0_CLOCK,
    input wire logic TIMER0_EVENT_CLOCK,
    input wire logic SLOW_CLOCK_OUTPUT,
    input wire logic FAST_CLOCK_OUTPUT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RESET);
    // one wait cycle, then back high
    property p_wait_one;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer");
    property p_wait_pulse;
        !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("wait low");
    // oscillator enable and every clock output but the timer 1 event clock off after reset
    property p_reset_clear;
        $fell(RESET) |-> !(FAST_OSC_ENABLE || TIMER0_CLOCK ||
            TIMER0_EVENT_CLOCK || SLOW_CLOCK_OUTPUT || FAST_CLOCK_OUTPUT);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("rst");
    // enable pin moves only after a write
    property p_osc_en;
        $changed(FAST_OSC_ENABLE) |-> $past(AVS_WRITE) ||
            $past(AVS_WRITE, 2);
    endproperty
    a_osc_en: assert property (p_osc_en) else $error("osc en moved");
    property p_read_upper;
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper");
    // gated event follows its pin
    property p_event0;
        $rose(TIMER0_EVENT_CLOCK) |-> $past(TIMER0_EVENT_INPUT, 2) ||
            $past(TIMER0_EVENT_INPUT, 3) || $past(TIMER0_EVENT_INPUT, 4);
    endproperty
    a_event0: assert property (p_event0) else $error("event");
    // no truncated high pulses
    property p_slow_pulse;
        $rose(SLOW_CLOCK_OUTPUT) |=> SLOW_CLOCK_OUTPUT [*2];
    endproperty
    a_slow_pulse: assert property (p_slow_pulse) else $error("slow");
    property p_fast_pulse;
        $rose(FAST_CLOCK_OUTPUT) |=> FAST_CLOCK_OUTPUT [*2];
    endproperty
    a_fast_pulse: assert property (p_fast_pulse) else $error("fast");
    property p_t0_pulse;
        $rose(TIMER0_CLOCK) |=> TIMER0_CLOCK [*2];
    endproperty
    a_t0_pulse: assert property (p_t0_pulse) else $error("t0");
endmodule : pcc_chk
bind pcc_prescaler pcc_chk pcc_chk_i (.SYS_CLK(SYS_CLK), .RESET(RESET),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TIMER0_EVENT_INPUT(TIMER0_EVENT_INPUT),
    .FAST_OSC_ENABLE(FAST_OSC_ENABLE), .TIMER0_CLOCK(TIMER0_CLOCK),
    .TIMER0_EVENT_CLOCK(TIMER0_EVENT_CLOCK),
    .SLOW_CLOCK_OUTPUT(SLOW_CLOCK_OUTPUT),
    .FAST_CLOCK_OUTPUT(FAST_CLOCK_OUTPUT));

//--- bench/tb_prescaler_clock_control.sv
// self-checking bench for the prescaler block
`timescale 1ns/1ps
module tb_prescaler_clock_control;
    localparam logic [15:0] IDX [6] = '{pcc_pkg::OSC_CTRL_IDX,
        pcc_pkg::PRESCALE_SEL_IDX, pcc_pkg::SOURCE_SEL_IDX,
        pcc_pkg::CLK_OUT_CTRL_IDX, pcc_pkg::EVENT_GATE_IDX, 16'hFF13};
    localparam logic [7:0] MSK [6] = '{8'h04, 8'h0F, 8'h01, 8'hFF, 8'h03,
        8'h00};
    logic SYS_CLK = 0, RESET = 1, rd = 0, wr = 0, waitreq;
    logic [pcc_pkg::ADDR_W-1:0] adr = '0;
    logic [31:0] wdat = '0, rdat;
    logic slow = 0, fast = 0, ev0 = 0, ev1 = 0, fen, t0c, e0c, e1c, so, fo;
    int n_fail = 0, samples_checked = 0, hs, cs = 0, cf = 0;
    logic [31:0] expq [$];
    wire [2:0] clks = {t0c, so, fo};
    pcc_prescaler pcc_prescaler_i (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdat),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq), .SLOW_OSC_CLK(slow),
        .FAST_OSC_CLK(fast), .TIMER0_EVENT_INPUT(ev0), .TIMER1_EVENT_INPUT(ev1),
        .FAST_OSC_ENABLE(fen), .TIMER0_CLOCK(t0c), .TIMER0_EVENT_CLOCK(e0c),
        .TIMER1_EVENT_CLOCK(e1c), .SLOW_CLOCK_OUTPUT(so),
        .FAST_CLOCK_OUTPUT(fo));
    initial forever #5 SYS_CLK = ~SYS_CLK;
    // oscillators; fast one ends its half cycle low when stopped
    always @(posedge SYS_CLK) begin
        cs <= (cs == 4) ? 0 : cs + 1;
        if (cs == 4)
            slow <= ~slow;
        if (fen || fast)
            cf <= (cf == 2) ? 0 : cf + 1;
        if ((fen || fast) && cf == 2)
            fast <= ~fast;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // read data against the oldest note
    always @(posedge SYS_CLK) begin
        if (rd && !waitreq)
            check("read", rdat, expq.pop_front());
    end
    task automatic bus(input logic [15:0] idx, input logic w,
        input logic [7:0] d);
        int t;
        t = 0;
        @(posedge SYS_CLK);
        adr <= {idx, 2'h0};
        wr <= w;
        rd <= !w;
        wdat <= {24'h0, d};
        @(posedge SYS_CLK);
        while (waitreq && t < 50) begin
            @(posedge SYS_CLK);
            t++;
        end
        if (t == 50)
            n_fail++;
        wr <= 0;
        rd <= 0;
    endtask : bus
    task automatic rd_reg(input logic [15:0] idx, input logic [7:0] e);
        expq.push_back({24'h0, e});
        bus(idx, 1'h0, 8'h00);
    endtask : rd_reg
    // cycles between second and third rise
    task automatic period(input int sel, input int exp);
        int n, r;
        logic p;
        n = 0;
        r = 0;
        p = clks[sel];
        while (r < 3 && n < 4000) begin
            @(posedge SYS_CLK);
            n++;
            if (clks[sel] && !p) begin
                r++;
                if (r == 2)
                    n = 0;
            end
            p = clks[sel];
        end
        check("period", 32'(n), 32'(exp));
    endtask : period
    task automatic highs(input int sel);
        hs = 0;
        repeat (300) begin
            @(posedge SYS_CLK);
            hs += int'(clks[sel]);
        end
    endtask : highs
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (100000) @(posedge SYS_CLK);
        n_fail++;
        final_report();
    end
    // main sequence
    initial begin
        logic [7:0] v;
        v = 8'($urandom(59753));
        repeat (3) @(posedge SYS_CLK);
        RESET <= 0;
        foreach (IDX[i]) rd_reg(IDX[i], 8'h00);
        foreach (IDX[i]) begin
            v = 8'($urandom);
            bus(IDX[i], 1'h1, v);
            rd_reg(IDX[i], v & MSK[i]);
        end
        bus(IDX[0], 1'h1, 8'h04);
        repeat (2) @(posedge SYS_CLK);
        check("osc_en", {31'h0, fen}, 32'h1);
        for (int c = 0; c < 8; c++) begin
            bus(IDX[3], 1'h1, {1'h1, 3'(c), 1'h1, 3'(c)});
            period(0, 6 << c);
            period(1, 10 << c);
        end
        repeat (3) begin
            v = 8'($urandom);
            bus(IDX[2], 1'h1, {7'h0, v[7]});
            bus(IDX[1], 1'h1, {4'h0, 1'h1, v[2:0]});
            // let the gate pick up the new setting first
            repeat (1400) @(posedge SYS_CLK);
            period(2, (v[7] ? 10 : 6) << v[2:0]);
        end
        bus(IDX[1], 1'h1, 8'h07);
        bus(IDX[3], 1'h1, 8'h00);
        // slowest high phase must finish before the gates close
        repeat (1400) @(posedge SYS_CLK);
        highs(2);
        check("t0_off", 32'(hs), 32'h0);
        highs(0);
        check("fast_off", 32'(hs), 32'h0);
        bus(IDX[3], 1'h1, 8'h88);
        bus(IDX[0], 1'h1, 8'h00);
        repeat (10) @(posedge SYS_CLK);
        highs(0);
        check("osc_stop", 32'(hs), 32'h0);
        highs(1);
        check("slow_on", 32'(hs > 0), 32'h1);
        bus(IDX[4], 1'h1, 8'h01);
        ev0 <= 1;
        ev1 <= 1;
        repeat (6) @(posedge SYS_CLK);
        check("gate0", {30'h0, e1c, e0c}, 32'h1);
        bus(IDX[4], 1'h1, 8'h02);
        repeat (6) @(posedge SYS_CLK);
        check("gate1", {30'h0, e1c, e0c}, 32'h2);
        ev0 <= 0;
        RESET <= 1;
        repeat (3) @(posedge SYS_CLK);
        RESET <= 0;
        rd_reg(IDX[3], 8'h00);
        rd_reg(IDX[4], 8'h00);
        final_report();
    end
endmodule : tb_prescaler_clock_control
